// File: design/jks_top.sv
// Top of the J-K Mealy sequencer core: pin sampling, arrays, clocking and output drivers.
`timescale 1ns/10ps
`include "jks_map.svh"

module jks_top
  import jks_pkg::*;
(
  // Clock and reset
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_rst_n,
  // Configuration image
  input  wire jks_cfg_type                 i_cfg,
  // Pins from surrounding logic, asynchronous to the reference clock
  input  wire logic                        i_primary_clock_pin,
  input  wire logic                        i_secondary_clock_pin,
  input  wire logic [`JKS_NUM_INPUTS-1:0]  i_logic_inputs,
  input  wire logic                        i_init_oe_pin,
  input  wire jks_diag_type                i_diag,
  // Registered output pins, three signals of a two-way pin
  input  wire logic [`JKS_NUM_BITS-1:0]    i_registered_output_pins,
  output logic      [`JKS_NUM_BITS-1:0]    o_registered_output_pins,
  output logic      [`JKS_NUM_BITS-1:0]    o_registered_output_pins_oe,
  // Register contents for observation
  output logic      [`JKS_NUM_BITS-1:0]    o_state_bits,
  output logic      [`JKS_NUM_BITS-1:0]    o_output_bit_value
);

  // ****************************************************************
  // Types and state
  // ****************************************************************
  // All state of this module except the reset synchroniser lives in one record, filled by one process.
  typedef struct packed {
    logic [`JKS_NUM_INPUTS-1:0] in_s1;
    logic [`JKS_NUM_INPUTS-1:0] in_s2;
    logic [`JKS_NUM_BITS-1:0]   pin_s1;
    logic [`JKS_NUM_BITS-1:0]   pin_s2;
    logic [2:0]                 diag_s1;
    logic [2:0]                 diag_s2;
    logic [2:0]                 ctl_s1;   // clock 1, clock 2, init/oe
    logic [2:0]                 ctl_s2;
    logic                       primary_clock_pin_prev;
    logic                       secondary_clock_pin_prev;
    logic                       armed_lo;
    logic                       armed_hi;
    logic [`JKS_NUM_BITS-1:0]   fout;
    logic [`JKS_NUM_BITS-1:0]   fout_oe;
    logic [`JKS_NUM_BITS-1:0]   st_obs;
    logic [`JKS_NUM_BITS-1:0]   out_obs;
  } jks_top_state_type;

  jks_top_state_type                st_q;
  jks_top_state_type                st_d;
  logic [1:0]                       rst_sync_q;
  logic                             rst_n_int;

  // Internal nets between the arrays and the register file.
  jks_cfg_type                      cfg;
  jks_diag_type                     diag;
  logic [`JKS_NUM_REGS-1:0]         regs;
  logic [`JKS_NUM_LITS-1:0]         lits;
  logic [`JKS_NUM_LITS-1:0]         lits_pre;
  logic [`JKS_NUM_TERMS-1:0]        terms_pre;
  logic [`JKS_NUM_TERMS-1:0]        terms;
  logic [`JKS_NUM_COMP-1:0]         comp;
  logic [`JKS_NUM_REGS-1:0]         j_in;
  logic [`JKS_NUM_REGS-1:0]         k_in;
  logic [`JKS_NUM_REGS-1:0]         bit_en;
  logic                             primary_clock_pin_lvl;
  logic                             secondary_clock_pin_lvl;
  logic                             hi_lvl;
  logic                             rise_lo;
  logic                             fall_lo;
  logic                             rise_hi;
  logic                             fall_hi;
  logic                             secondary_clock_pin_on;
  logic                             oe_mode;
  logic                             init_act;
  logic                             pin_lvl;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  // Every flop of the core leaves reset on the same edge, so no half of the
  // machine can step while the other half is still held.
  // Assertion is immediate; release is delayed two clocks to avoid metastable exit.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_q <= `JKS_SYNC_RESET;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync_q[1];

  // ****************************************************************
  // Configuration defaults
  // ****************************************************************
  // A half-built image must never reach the arrays, so the default is forced
  // field by field rather than trusting the image to be all zero.
  // Without a valid image the core behaves as an unprogrammed part.
  always_comb begin
    cfg = i_cfg;
    if (!i_cfg.valid) begin
      cfg.oe_mode         = 1'b0;
      cfg.secondary_clock_pin_en         = 1'b0;
      cfg.j_sel           = '0;
      cfg.k_sel           = '0;
      cfg.init_programmed = 1'b0;
    end
  end

  // Configuration levels, and pin levels that the rest of the core reads after the two sync stages.
  assign secondary_clock_pin_on  = cfg.secondary_clock_pin_en;
  assign oe_mode  = cfg.oe_mode;
  assign primary_clock_pin_lvl = st_q.ctl_s2[0];
  assign secondary_clock_pin_lvl = st_q.ctl_s2[1];
  assign pin_lvl  = st_q.ctl_s2[2];
  assign diag     = jks_diag_type'(st_q.diag_s2);

  // Init is taken after the pin synchroniser, so it acts two reference clocks
  // late, and a pulse shorter than one reference clock may be missed.
  // pin is init or enable, never both
  assign init_act = ~oe_mode & cfg.init_programmed & pin_lvl;

  // ****************************************************************
  // Clock edge detection
  // ****************************************************************
  // The clock pins are sampled as data, not used as clocks: each level must
  // last one reference clock or an edge may be lost. This trades pin speed for
  // a single clock domain.
  // rising edges clock registers
  assign hi_lvl  = secondary_clock_pin_on ? secondary_clock_pin_lvl : primary_clock_pin_lvl;
  assign rise_lo = primary_clock_pin_lvl & ~st_q.primary_clock_pin_prev;
  assign fall_lo = ~primary_clock_pin_lvl & st_q.primary_clock_pin_prev;
  assign rise_hi = hi_lvl & ~(secondary_clock_pin_on ? st_q.secondary_clock_pin_prev : st_q.primary_clock_pin_prev);
  assign fall_hi = ~hi_lvl & (secondary_clock_pin_on ? st_q.secondary_clock_pin_prev : st_q.primary_clock_pin_prev);

  // A half that is not armed ignores rising edges until a fall is seen.
  // upper halves on second clock
  genvar g;
  generate
    for (g = 0; g < `JKS_NUM_REGS; g = g + 1) begin : g_en
      if ((g % `JKS_NUM_BITS) < `JKS_HALF_BITS) begin : g_lo
        assign bit_en[g] = rise_lo & st_q.armed_lo & ~init_act;
      end else begin : g_hi
        assign bit_en[g] = rise_hi & st_q.armed_hi & ~init_act;
      end
    end
  endgenerate

  // ****************************************************************
  // Arrays
  // ****************************************************************
  // Literal order is inputs, then state bits, then the complement outputs.
  assign lits     = {comp, regs[`JKS_NUM_BITS-1:0], st_q.in_s2};
  // The first pass gets zeros in place of the complement outputs. Masking alone
  // would still leave a structural loop from each complement into its own
  // terms, which timing tools report as combinational feedback.
  assign lits_pre = {{`JKS_NUM_COMP{1'b0}}, regs[`JKS_NUM_BITS-1:0], st_q.in_s2};

  // First pass finds which terms feed the complement arrays.
  jks_term_array u_pass1 (
    .i_cfg       (cfg),
    .i_mask_comp (1'b1),
    .i_lits      (lits_pre),
    .o_terms     (terms_pre)
  );

  // Each complement sees only the terms selected for it, so two machines can
  // keep separate else-conditions.
  // two independent complement arrays
  generate
    for (g = 0; g < `JKS_NUM_COMP; g = g + 1) begin : g_comp
      assign comp[g] = ~|(terms_pre & cfg.comp_sel[g]);
    end
  endgenerate

  // Second pass sees the complement literals.
  // Terms that read a complement literal settle one array delay later.
  jks_term_array u_pass2 (
    .i_cfg       (cfg),
    .i_mask_comp (1'b0),
    .i_lits      (lits),
    .o_terms     (terms)
  );

  // A term with no select bit set drives neither input, so the flop holds.
  // J and K OR of terms
  generate
    for (g = 0; g < `JKS_NUM_REGS; g = g + 1) begin : g_or
      assign j_in[g] = |(terms & cfg.j_sel[g]);
      assign k_in[g] = |(terms & cfg.k_sel[g]);
    end
  endgenerate

  // Sixteen J-K flops; init and diagnostic loads are resolved inside.
  jks_jk_reg u_regs (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (rst_n_int),
    .i_en        (bit_en),
    .i_j         (j_in),
    .i_k         (k_in),
    .i_init      (init_act),
    .i_init_val  (cfg.init_val),
    .i_diag      (diag),
    .i_load_data (st_q.pin_s2),
    .o_q         (regs)
  );

  // ****************************************************************
  // Sampling, arming and output drivers
  // ****************************************************************
  // Pins pass two flops; the first stage feeds only the second.
  always_comb begin
    st_d           = st_q;
    st_d.in_s1     = i_logic_inputs;
    st_d.in_s2     = st_q.in_s1;
    st_d.pin_s1    = i_registered_output_pins;
    st_d.pin_s2    = st_q.pin_s1;
    st_d.diag_s1   = i_diag;
    st_d.diag_s2   = st_q.diag_s1;
    st_d.ctl_s1    = {i_init_oe_pin, i_secondary_clock_pin, i_primary_clock_pin};
    st_d.ctl_s2    = st_q.ctl_s1;
    st_d.primary_clock_pin_prev = primary_clock_pin_lvl;
    st_d.secondary_clock_pin_prev = secondary_clock_pin_lvl;
    // Init wins over a fall in the same cycle, so the lockout cannot be skipped.
    // disarm during init, rearm on fall
    if (init_act) begin
      st_d.armed_lo = 1'b0;
      st_d.armed_hi = 1'b0;
    end else begin
      if (fall_lo) begin
        st_d.armed_lo = 1'b1;
      end
      if (fall_hi) begin
        st_d.armed_hi = 1'b1;
      end
    end
    // The enable is registered with the value, so both change on the same edge
    // and a pin never shows a stale value while it turns on.
    // Output pins show state bits when asked, else the output register.
    st_d.fout    = diag.show_state ? regs[`JKS_NUM_BITS-1:0] : regs[`JKS_NUM_REGS-1:`JKS_NUM_BITS];
    if (diag.load_state || diag.load_out || (oe_mode && pin_lvl)) begin
      st_d.fout_oe = '0;
    end else begin
      st_d.fout_oe = '1;
    end
    // Observation copies follow the registers one clock late, like the pins.
    st_d.st_obs  = regs[`JKS_NUM_BITS-1:0];
    st_d.out_obs = regs[`JKS_NUM_REGS-1:`JKS_NUM_BITS];
  end

  // Limitation: the first rising edge after power-up is taken even without a
  // preceding fall, since no clock history exists yet.
  // Power-up arms both halves so the first rising edge already counts.
  always_ff @(posedge i_ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      st_q          <= '0;
      st_q.armed_lo <= 1'b1;
      st_q.armed_hi <= 1'b1;
      st_q.fout     <= '1;
      st_q.st_obs   <= '1;
      st_q.out_obs  <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  // Every output comes straight from a flop of the state record.
  assign o_registered_output_pins    = st_q.fout;
  assign o_registered_output_pins_oe = st_q.fout_oe;
  assign o_state_bits                = st_q.st_obs;
  assign o_output_bit_value          = st_q.out_obs;

endmodule

// File: design/jks_map.svh
// Constants for the J-K Mealy sequencer core: sizes, indices, reset values and field positions.
`ifndef JKS_MAP_SVH
`define JKS_MAP_SVH

// ****************************************************************
// Array sizes
// ****************************************************************
`define JKS_NUM_TERMS   64
`define JKS_NUM_INPUTS  16
`define JKS_NUM_BITS    8
`define JKS_NUM_REGS    16
`define JKS_NUM_COMP    2
`define JKS_NUM_LITS    26

// ****************************************************************
// Literal positions inside the product-term input vector
// ****************************************************************
`define JKS_LIT_IN_LO   0
`define JKS_LIT_ST_LO   16
`define JKS_LIT_CP_LO   24

// ****************************************************************
// Register halves and reset values
// ****************************************************************
`define JKS_HALF_BITS   4
`define JKS_POWERUP_VAL 16'hffff
`define JKS_SYNC_RESET  2'h0

`endif

// File: design/jks_pkg.sv
// Types shared by the J-K Mealy sequencer core.
`include "jks_map.svh"

package jks_pkg;

  // Configuration image, the equivalent of the programmed links.
  typedef struct packed {
    logic                                                 valid;
    logic                                                 oe_mode;
    logic                                                 secondary_clock_pin_en;
    logic                                                 init_programmed;
    logic [`JKS_NUM_REGS-1:0]                             init_val;
    logic [`JKS_NUM_TERMS-1:0][`JKS_NUM_LITS-1:0]         lit_true;
    logic [`JKS_NUM_TERMS-1:0][`JKS_NUM_LITS-1:0]         lit_compl;
    logic [`JKS_NUM_REGS-1:0][`JKS_NUM_TERMS-1:0]         j_sel;
    logic [`JKS_NUM_REGS-1:0][`JKS_NUM_TERMS-1:0]         k_sel;
    logic [`JKS_NUM_COMP-1:0][`JKS_NUM_TERMS-1:0]         comp_sel;
  } jks_cfg_type;

  // Diagnostic mode selects, the equivalent of the high-voltage levels.
  typedef struct packed {
    logic show_state;
    logic load_state;
    logic load_out;
  } jks_diag_type;

  // Register file state: state bits low, output bits high.
  typedef struct packed {
    logic [`JKS_NUM_REGS-1:0] q;
  } jks_reg_state_type;

endpackage

// File: design/jks_term_array.sv
// Product-term AND array of the J-K Mealy sequencer core.
`timescale 1ns/10ps
`include "jks_map.svh"

module jks_term_array
  import jks_pkg::*;
(
  // Configuration and pass select
  input  wire jks_cfg_type             i_cfg,
  input  wire logic                    i_mask_comp,
  // Literals and terms
  input  wire logic [`JKS_NUM_LITS-1:0]  i_lits,
  output logic      [`JKS_NUM_TERMS-1:0] o_terms
);

  // ****************************************************************
  // One AND gate per transition term
  // ****************************************************************
  genvar t;
  generate
    for (t = 0; t < `JKS_NUM_TERMS; t = t + 1) begin : g_term
      logic [`JKS_NUM_LITS-1:0] hit;
      logic [`JKS_NUM_LITS-1:0] keep;
      // The first pass ignores complement literals so the feedback cannot loop.
      assign keep = i_mask_comp ? {{`JKS_NUM_COMP{1'b0}}, {(`JKS_NUM_LITS-`JKS_NUM_COMP){1'b1}}}
                                : {`JKS_NUM_LITS{1'b1}};
      assign hit = ~keep | ((~i_cfg.lit_true[t] | i_lits) & (~i_cfg.lit_compl[t] | ~i_lits));
      assign o_terms[t] = i_cfg.valid & (&hit);
    end
  endgenerate

endmodule

// File: design/jks_jk_reg.sv
// Sixteen J-K flip-flops with power-up preset, initialization and diagnostic load.
`timescale 1ns/10ps
`include "jks_map.svh"

module jks_jk_reg
  import jks_pkg::*;
(
  // Clock and reset
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rst_n,
  // Per-bit clock enables and J-K inputs
  input  wire logic [`JKS_NUM_REGS-1:0]   i_en,
  input  wire logic [`JKS_NUM_REGS-1:0]   i_j,
  input  wire logic [`JKS_NUM_REGS-1:0]   i_k,
  // Initialization
  input  wire logic                       i_init,
  input  wire logic [`JKS_NUM_REGS-1:0]   i_init_val,
  // Diagnostic load
  input  wire jks_diag_type               i_diag,
  input  wire logic [`JKS_NUM_BITS-1:0]   i_load_data,
  // Register contents
  output logic      [`JKS_NUM_REGS-1:0]   o_q
);

  jks_reg_state_type state_q;
  jks_reg_state_type state_d;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Initialization wins over everything; otherwise each enabled bit steps.
  always_comb begin
    state_d = state_q;
    for (int b = 0; b < `JKS_NUM_REGS; b = b + 1) begin
      if (i_init) begin
        state_d.q[b] = i_init_val[b];
      end else if (i_en[b]) begin
        if (b < `JKS_NUM_BITS && i_diag.load_state) begin
          state_d.q[b] = i_load_data[b % `JKS_NUM_BITS];
        end else if (b >= `JKS_NUM_BITS && i_diag.load_out) begin
          state_d.q[b] = i_load_data[b % `JKS_NUM_BITS];
        end else if (b < `JKS_NUM_BITS && i_diag.load_out) begin
          state_d.q[b] = state_q.q[b];
        end else if (b >= `JKS_NUM_BITS && i_diag.load_state) begin
          state_d.q[b] = state_q.q[b];
        end else begin
          state_d.q[b] = (i_j[b] & ~state_q.q[b]) | (~i_k[b] & state_q.q[b]);
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= `JKS_POWERUP_VAL;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_q = state_q.q;

endmodule

// File: test/jks_top_chk.sv
// Port-level assertions for the sequencer core top.
`timescale 1ns/10ps

module jks_top_chk
  import jks_pkg::*;
(
  // Clock and reset
  input wire logic         i_ref_clk,
  input wire logic         i_rst_n,
  // Inputs of the core
  input wire jks_cfg_type  i_cfg,
  input wire logic         i_primary_clock_pin,
  input wire logic         i_secondary_clock_pin,
  input wire logic [15:0]  i_logic_inputs,
  input wire logic         i_init_oe_pin,
  input wire jks_diag_type i_diag,
  input wire logic [7:0]   i_registered_output_pins,
  // Outputs of the core
  input wire logic [7:0]   o_registered_output_pins,
  input wire logic [7:0]   o_registered_output_pins_oe,
  input wire logic [7:0]   o_state_bits,
  input wire logic [7:0]   o_output_bit_value
);
  logic       clk_seen_q;
  logic [3:0] since_q;
  logic       init_on;

  // Init is live only when programmed and the pin is not the enable.
  assign init_on = i_cfg.valid && i_cfg.init_programmed && !i_cfg.oe_mode && i_init_oe_pin;

  // Cycles since a primary clock rise or a high init/enable pin in either mode; saturates so it never wraps.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_seen_q <= 1'h0;
      since_q    <= 4'h0;
    end else begin
      clk_seen_q <= i_primary_clock_pin;
      if ((i_primary_clock_pin && !clk_seen_q) || i_init_oe_pin) begin
        since_q <= 4'h0;
      end else if (since_q != 4'hf) begin
        since_q <= since_q + 4'h1;
      end
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  // ****************
  // Assertions
  // ****************
  a_powerup_preset: assert property (
    $rose(i_rst_n) |-> o_state_bits == 8'hff && o_output_bit_value == 8'hff)
    else $error("registers not preset after reset");
  a_diag_oe_off: assert property (
    (i_diag.load_state || i_diag.load_out) [*4] |-> o_registered_output_pins_oe == 8'h00)
    else $error("pins driven during diagnostic load");
  a_oe_pin_off: assert property (
    (i_cfg.valid && i_cfg.oe_mode && i_init_oe_pin) [*4] |-> o_registered_output_pins_oe == 8'h00)
    else $error("pins driven while enable is off");
  a_default_init: assert property (
    (!i_cfg.valid && i_init_oe_pin && i_diag == 3'h0) [*4] |-> o_registered_output_pins_oe == 8'hff)
    else $error("default pin acted as enable");
  a_unprog_hold: assert property (
    (!i_cfg.valid && i_diag == 3'h0) [*4] |=> $stable(o_state_bits) && $stable(o_output_bit_value))
    else $error("unprogrammed registers changed");
  a_init_value: assert property (
    init_on [*6] |-> {o_output_bit_value, o_state_bits} == i_cfg.init_val)
    else $error("registers not at init value");
  a_init_hold: assert property (
    init_on [*7] |=> $stable(o_state_bits) && $stable(o_output_bit_value))
    else $error("clocking not inhibited during init");
  a_pins_follow: assert property (
    (i_diag == 3'h0) [*4] ##0 o_registered_output_pins_oe == 8'hff
      |-> o_registered_output_pins == o_output_bit_value)
    else $error("pins differ from output register");
  a_edge_only: assert property (
    !$stable(o_state_bits[3:0]) |-> since_q <= 4'h6)
    else $error("low state bits changed without a clock rise");

  c_init_load: cover property (init_on [*6]);
  c_diag_load: cover property (i_diag.load_state && $rose(i_primary_clock_pin));
  c_second_clk: cover property (i_cfg.secondary_clock_pin_en && $rose(i_secondary_clock_pin));
endmodule

bind jks_top jks_top_chk u_jks_top_chk (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cfg(i_cfg),
  .i_primary_clock_pin(i_primary_clock_pin), .i_secondary_clock_pin(i_secondary_clock_pin),
  .i_logic_inputs(i_logic_inputs), .i_init_oe_pin(i_init_oe_pin), .i_diag(i_diag),
  .i_registered_output_pins(i_registered_output_pins),
  .o_registered_output_pins(o_registered_output_pins),
  .o_registered_output_pins_oe(o_registered_output_pins_oe),
  .o_state_bits(o_state_bits), .o_output_bit_value(o_output_bit_value)
);

// File: test/jks_env_model.sv
// Surrounding-logic model: resolves the two-way output pins and forces load levels.
`timescale 1ns/10ps

module jks_env_model (
  // Clock
  input  wire logic       i_ref_clk,
  // Device side of the pins
  input  wire logic [7:0] i_dev_val,
  input  wire logic [7:0] i_dev_oe,
  // Levels forced by this logic during a diagnostic load
  input  wire logic       i_force_en,
  input  wire logic [7:0] i_force_val,
  // Level seen on the wire
  output logic      [7:0] o_wire
);
  logic [7:0] last_q = 8'h00;

  // outside drive during load
  // A released pin moves every cycle, so a stale level is never read as data.
  assign o_wire = i_force_en ? i_force_val : ((i_dev_oe & i_dev_val) | (~i_dev_oe & ~last_q));

  // Remember the wire level of the last cycle.
  always @(posedge i_ref_clk) begin
    last_q <= o_wire;
  end
endmodule

// File: test/test_jks_top.sv
// Self-checking bench for the sequencer core with a pin-side logic model.
`timescale 1ns/10ps

module test_jks_top
  import jks_pkg::*;
;
  logic         ref_clk = 1'h0;
  logic         rst_n;
  jks_cfg_type  cfg, nc;
  logic         pclk, sclk, init_pin, look, force_en;
  logic [15:0]  lin, cur;
  jks_diag_type diag;
  logic [7:0]   wire_lvl, pins, pins_oe, st, ob, force_val;
  logic [31:0]  exp_q[$];
  logic [1:0]   ops[6] = '{2'h3, 2'h0, 2'h1, 2'h3, 2'h2, 2'h3};
  int           err_total, samples_checked, cyc;
  integer       seed = 32'h1ba6;

  // Core under test.
  jks_top u_jks_top (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_cfg(cfg),
    .i_primary_clock_pin(pclk), .i_secondary_clock_pin(sclk),
    .i_logic_inputs(lin), .i_init_oe_pin(init_pin), .i_diag(diag),
    .i_registered_output_pins(wire_lvl), .o_registered_output_pins(pins),
    .o_registered_output_pins_oe(pins_oe), .o_state_bits(st), .o_output_bit_value(ob)
  );

  // Surrounding logic on the output pins.
  jks_env_model u_jks_env_model (
    .i_ref_clk(ref_clk), .i_dev_val(pins), .i_dev_oe(pins_oe),
    .i_force_en(force_en), .i_force_val(force_val), .o_wire(wire_lvl)
  );

  // Reference clock, 40 ns period.
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  // ****************
  // Tasks
  // ****************
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic do_reset();
    rst_n <= 1'h0;
    tick(12);
    rst_n <= 1'h1;
    tick(4);
  endtask

  // Random bits on the unused inputs keep the array honest.
  task automatic drive(input logic [15:0] v);
    lin <= (16'($random(seed)) & 16'hffe0) | v;
    tick(4);
  endtask

  // Clock pins stay high and low three cycles or more so the sync sees each level.
  task automatic pulse(input logic two);
    if (two) sclk <= 1'h1;
    else pclk <= 1'h1;
    tick(4);
    sclk <= 1'h0;
    pclk <= 1'h0;
    tick(4);
  endtask

  task automatic note_exp(input logic [23:0] e);
    tick(6);
    // Pins carry the output register, or the state bits while they are shown.
    exp_q.push_back({diag.show_state ? e[7:0] : e[15:8], e});
    look <= 1'h1;
    tick(1);
    look <= 1'h0;
  endtask

  // Init to the programmed value, then a held pulse on each clock pin clears the clock lockout.
  task automatic arm();
    init_pin <= 1'h1;
    tick(6);
    init_pin <= 1'h0;
    drive(16'h0000);
    pulse(1'h0);
    pulse(1'h1);
  endtask

  // Term 0 and 1 are inputs 0 and 1; terms 2 and 3 use the complement feedback.
  function automatic jks_cfg_type mk(input logic oe, c2, input logic [15:0] iv);
    jks_cfg_type c;
    c = '0;
    c.valid = 1'h1;
    c.oe_mode = oe;
    c.secondary_clock_pin_en = c2;
    c.init_programmed = 1'h1;
    c.init_val = iv;
    c.lit_true[0][0] = 1'h1;
    c.lit_true[1][1] = 1'h1;
    c.lit_true[2][24] = 1'h1;
    c.lit_true[2][3] = 1'h1;
    c.lit_true[3][25] = 1'h1;
    c.lit_true[3][3] = 1'h1;
    c.lit_true[4][4] = 1'h1;
    c.comp_sel[0] = 64'h1;
    c.comp_sel[1] = 64'h10;
    for (int r = 0; r < 16; r++) begin
      c.j_sel[r] = r < 8 ? 64'h5 : 64'h9;
      c.k_sel[r] = 64'h2;
    end
    return c;
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Takes the oldest note off the queue whenever a result is shown.
  always @(posedge ref_clk) begin
    if (look === 1'h1) begin
      samples_checked++;
      if ({pins, pins_oe, ob, st} !== exp_q[0]) begin
        err_total++;
        $display("[ERR] pins_oe_out_state expected %h seen %h", exp_q[0],
                 {pins, pins_oe, ob, st});
      end
      void'(exp_q.pop_front());
    end
  end

  // A hung run is cut short well past the expected length.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_total++;
      close_out();
    end
  end

  // ****************
  // Scenarios
  // ****************
  initial begin
    rst_n = 1'h0;
    // Unprogrammed part: a full image behind a clear valid bit must stay inert.
    nc = mk(1'h1, 1'h1, 16'h0000);
    nc.valid = 1'h0;
    cfg = nc;
    pclk = 1'h0;
    sclk = 1'h0;
    init_pin = 1'h0;
    look = 1'h0;
    force_en = 1'h0;
    force_val = 8'h00;
    lin = 16'h0000;
    diag = '0;
    do_reset();
    note_exp(24'hffffff);
    init_pin <= 1'h1;
    tick(6);
    init_pin <= 1'h0;
    drive(16'h0002);
    pulse(1'h0);
    pulse(1'h1);
    note_exp(24'hffffff);
    $display("test unprogrammed done");
    cur = 16'($random(seed));
    cfg <= mk(1'h0, 1'h0, cur);
    do_reset();
    init_pin <= 1'h1;
    tick(6);
    pulse(1'h0);
    note_exp({8'hff, cur});
    init_pin <= 1'h0;
    drive(16'h0003);
    pulse(1'h0);
    note_exp({8'hff, cur});
    for (int i = 0; i < 6; i++) begin
      drive({14'h0000, ops[i]});
      pulse(1'h0);
      cur = ops[i] == 2'h1 ? 16'hffff : ops[i] == 2'h2 ? 16'h0000 : ops[i] == 2'h3 ? ~cur : cur;
      note_exp({8'hff, cur});
    end
    $display("test init and jk done");
    cfg <= mk(1'h0, 1'h1, 16'h0000);
    do_reset();
    arm();
    drive(16'h0003);
    pulse(1'h0);
    note_exp(24'hff0f0f);
    pulse(1'h1);
    note_exp(24'hffffff);
    $display("test second clock done");
    cfg <= mk(1'h0, 1'h0, 16'h0000);
    do_reset();
    arm();
    drive(16'h0018);
    pulse(1'h0);
    note_exp(24'hff00ff);
    drive(16'h0008);
    pulse(1'h0);
    note_exp(24'hffffff);
    $display("test complement done");
    cur[7:0] = 8'($random(seed));
    drive(16'h0000);
    force_val <= cur[7:0];
    force_en <= 1'h1;
    diag <= 3'h2;
    tick(4);
    pulse(1'h0);
    note_exp({16'h00ff, cur[7:0]});
    cur[15:8] = 8'($random(seed));
    force_val <= cur[15:8];
    diag <= 3'h1;
    tick(4);
    pulse(1'h0);
    note_exp({8'h00, cur});
    diag <= 3'h0;
    force_en <= 1'h0;
    note_exp({8'hff, cur});
    diag <= 3'h4;
    note_exp({8'hff, cur});
    diag <= 3'h0;
    $display("test diagnostic load done");
    cfg <= mk(1'h1, 1'h0, 16'h5a5a);
    do_reset();
    init_pin <= 1'h1;
    tick(4);
    note_exp(24'h00ffff);
    init_pin <= 1'h0;
    note_exp(24'hffffff);
    nc = mk(1'h0, 1'h0, 16'h5a5a);
    nc.init_programmed = 1'h0;
    cfg <= nc;
    init_pin <= 1'h1;
    tick(6);
    note_exp(24'hffffff);
    init_pin <= 1'h0;
    $display("test enable mode done");
    close_out();
  end
endmodule
